// ==== core/stt_top.sv ====
// system timer trio: periodic, watchdog and real-time timers behind apb
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "stt_cfg.svh"
module stt_top (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic slow_clock_in,
   input wire logic debug_mode_in,
   input wire stt_pkg::stt_apb_req_t apb_in,
   output var stt_pkg::stt_apb_rsp_t apb_out,
   output logic irq_out,
   output logic overflow_out_n_out,
   output logic system_reset_out
);
   // one down-count step shared by three counters; load 0 means 65536
   function automatic stt_pkg::stt_dn_t stt_dn(
      input logic [15:0] c,
      input logic [15:0] ld
   );
      stt_pkg::stt_dn_t r;
      r.evt = (c == 16'h0001);
      r.nxt = r.evt ? ld : c - 16'h0001;
      return r;
   endfunction : stt_dn

   logic slow_last_q;
   logic slow_tick;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic acc;
   logic commit;
   logic wr;
   logic rd;
   logic [15:0] pimr_q;
   logic [17:0] wdmr_q;
   logic [15:0] rtmr_q;
   logic [19:0] alrm_q;
   logic [3:0] mask_q;
   logic [3:0] stat_q;
   logic [3:0] stat_set;
   logic [15:0] per_cnt_q;
   logic [15:0] wd_cnt_q;
   logic [6:0] wd_pre_q;
   logic [15:0] rt_pre_q;
   logic [19:0] rtc_q;
   logic [19:0] rtc_inc;
   logic [3:0] ext_cnt_q;
   logic [3:0] ext_cnt_d;
   logic irq_q;
   logic ovf_n_q;
   logic sysrst_q;
   logic pimr_wr;
   logic wdmr_wr;
   logic rtmr_wr;
   logic wd_restart;
   logic ien_wr;
   logic idis_wr;
   logic alrm_wr;
   logic stat_rd;
   logic wd_tick;
   logic map_ok;
   logic [31:0] rd_mux;
   stt_pkg::stt_dn_t per_s;
   stt_pkg::stt_dn_t wd_s;
   stt_pkg::stt_dn_t rt_s;
   logic per_evt;
   logic wd_ovf;
   logic rt_evt;
   logic alm_hit;

   assign apb_out.prdata = prdata_q;
   assign apb_out.pready = pready_q;
   assign apb_out.pslverr = pslverr_q;
   assign irq_out = irq_q;
   assign overflow_out_n_out = ovf_n_q;
   assign system_reset_out = sysrst_q;

   // slow clock is a synchronous level; its rising edge is the tick
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         slow_last_q <= 1'b0;
      else if (clk_en_in)
         slow_last_q <= slow_clock_in;
   end
   assign slow_tick = slow_clock_in & ~slow_last_q;

   // apb: one wait state; effects land on the edge that samples pready
   assign acc = apb_in.psel & apb_in.penable;
   assign commit = acc & pready_q;
   assign wr = commit & apb_in.pwrite & map_ok;
   assign rd = commit & ~apb_in.pwrite & map_ok;

   always_comb
   begin
      map_ok = (apb_in.paddr[1:0] == 2'b00);
      rd_mux = 32'h0000_0000;
      unique case (apb_in.paddr)
         `STT_OFS_CTRL, `STT_OFS_IEN, `STT_OFS_IDIS:
            rd_mux = 32'h0000_0000;
         `STT_OFS_PIMR:
            rd_mux = {16'h0000, pimr_q};
         `STT_OFS_WDMR:
            rd_mux = {14'h0000, wdmr_q};
         `STT_OFS_RTMR:
            rd_mux = {16'h0000, rtmr_q};
         `STT_OFS_STAT:
            rd_mux = {28'h000_0000, stat_q};
         `STT_OFS_IMSK:
            rd_mux = {28'h000_0000, mask_q};
         `STT_OFS_ALRM:
            rd_mux = {12'h000, alrm_q};
         `STT_OFS_CURR:
            rd_mux = {12'h000, rtc_q};
         default:
            map_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else if (clk_en_in)
      begin
         pready_q <= acc & ~pready_q;
         pslverr_q <= acc & ~pready_q & ~map_ok;
         // unmapped reads answer zero with pslverr
         prdata_q <= (acc & ~pready_q & ~apb_in.pwrite & map_ok) ? rd_mux : 32'h0000_0000;
      end
   end

   assign pimr_wr = wr & (apb_in.paddr == `STT_OFS_PIMR);
   assign wdmr_wr = wr & (apb_in.paddr == `STT_OFS_WDMR);
   assign rtmr_wr = wr & (apb_in.paddr == `STT_OFS_RTMR);
   assign ien_wr = wr & (apb_in.paddr == `STT_OFS_IEN);
   assign idis_wr = wr & (apb_in.paddr == `STT_OFS_IDIS);
   assign alrm_wr = wr & (apb_in.paddr == `STT_OFS_ALRM);
   assign stat_rd = rd & (apb_in.paddr == `STT_OFS_STAT);
   // a control write without the restart bit does nothing
   assign wd_restart = wr & (apb_in.paddr == `STT_OFS_CTRL) & apb_in.pwdata[`STT_BIT_RESTART];

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pimr_q <= `STT_RST_PIMR;
         wdmr_q <= `STT_RST_WDMR;
         rtmr_q <= `STT_RST_RTMR;
         alrm_q <= `STT_RST_ALRM;
      end
      else if (clk_en_in)
      begin
         if (pimr_wr)
            pimr_q <= apb_in.pwdata[15:0];
         if (wdmr_wr)
            wdmr_q <= apb_in.pwdata[17:0];
         if (rtmr_wr)
            rtmr_q <= apb_in.pwdata[15:0];
         if (alrm_wr)
            alrm_q <= apb_in.pwdata[19:0];
      end
   end

   // periodic interval timer
   assign per_s = stt_dn(per_cnt_q, pimr_q);
   assign per_evt = slow_tick & per_s.evt;

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         per_cnt_q <= 16'h0000;
      else if (clk_en_in)
      begin
         if (pimr_wr)
            per_cnt_q <= apb_in.pwdata[15:0];
         else if (slow_tick)
            per_cnt_q <= per_s.nxt;
      end
   end

   // watchdog: prescaler frozen in debug, so no overflow can follow
   assign wd_tick = slow_tick & ~debug_mode_in & (wd_pre_q == `STT_WD_PRE_LAST);
   assign wd_s = stt_dn(wd_cnt_q, wdmr_q[15:0]);
   assign wd_ovf = wd_tick & wd_s.evt & ~wd_restart;

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         wd_pre_q <= 7'h00;
      else if (clk_en_in)
      begin
         if (wd_restart)
            wd_pre_q <= 7'h00;
         else if (slow_tick & ~debug_mode_in)
            wd_pre_q <= wd_pre_q + 7'h01;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         wd_cnt_q <= 16'h0000;
      else if (clk_en_in)
      begin
         if (wd_restart)
            wd_cnt_q <= wdmr_q[15:0];
         else if (wd_tick)
            wd_cnt_q <= wd_s.nxt;
      end
   end

   // external pulse counts slow cycles, so its length tracks the slow clock
   always_comb
   begin
      ext_cnt_d = ext_cnt_q;
      if (wd_ovf & wdmr_q[`STT_BIT_EXTERNAL_PULSE_ENABLE])
         ext_cnt_d = `STT_EXT_PULSE;
      else if (slow_tick & (ext_cnt_q != 4'h0))
         ext_cnt_d = ext_cnt_q - 4'h1;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ext_cnt_q <= 4'h0;
         ovf_n_q <= 1'b1;
         sysrst_q <= 1'b0;
      end
      else if (clk_en_in)
      begin
         ext_cnt_q <= ext_cnt_d;
         ovf_n_q <= (ext_cnt_d == 4'h0);
         sysrst_q <= wd_ovf & wdmr_q[`STT_BIT_OVERFLOW_RESET_ENABLE];
      end
   end

   // real-time timer
   assign rt_s = stt_dn(rt_pre_q, rtmr_q);
   assign rt_evt = slow_tick & rt_s.evt & ~rtmr_wr;
   assign rtc_inc = rtc_q + 20'h00001;
   // compare only on increments so a reset value of zero waits a full wrap
   assign alm_hit = rt_evt & (rtc_inc == alrm_q);

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rt_pre_q <= `STT_RST_RTMR;
         rtc_q <= 20'h00000;
      end
      else if (clk_en_in)
      begin
         if (rtmr_wr)
         begin
            rt_pre_q <= apb_in.pwdata[15:0];
            rtc_q <= 20'h00000;
         end
         else
         begin
            if (slow_tick)
               rt_pre_q <= rt_s.nxt;
            if (rt_evt)
               rtc_q <= rtc_inc;
         end
      end
   end

   // status: a set in the clearing read cycle survives the clear
   always_comb
   begin
      stat_set = 4'h0;
      stat_set[`STT_FLG_PER] = per_evt;
      stat_set[`STT_FLG_WDOG] = wd_ovf;
      stat_set[`STT_FLG_RINC] = rt_evt;
      stat_set[`STT_FLG_ALRM] = alm_hit;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         stat_q <= 4'h0;
      else if (clk_en_in)
         stat_q <= (stat_q & {4{~stat_rd}}) | stat_set;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         mask_q <= 4'h0;
      else if (clk_en_in)
      begin
         if (ien_wr)
            mask_q <= mask_q | apb_in.pwdata[3:0];
         else if (idis_wr)
            mask_q <= mask_q & ~apb_in.pwdata[3:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         irq_q <= 1'b0;
      else if (clk_en_in)
         irq_q <= |(stat_q & mask_q);
   end

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in || !clk_en_in);

   AST_PER_FLAG: assert property (per_evt |=> stat_q[`STT_FLG_PER])
      else $error("periodic zero did not set its flag");
   AST_PER_RELOAD: assert property (per_evt && !pimr_wr |=> per_cnt_q == $past(pimr_q))
      else $error("periodic counter not reloaded after zero");
   AST_PIMR_WR: assert property (pimr_wr |=> per_cnt_q == $past(apb_in.pwdata[15:0]))
      else $error("period write did not reload counter");
   AST_PER_ZERO: assert property (slow_tick && per_cnt_q == 16'h0000 && !pimr_wr
      |=> per_cnt_q == 16'hffff && !stat_set[`STT_FLG_PER])
      else $error("zero period not treated as longest");
   AST_WD_RESTART: assert property (wd_restart
      |=> wd_cnt_q == $past(wdmr_q[15:0]) && wd_pre_q == 7'h00)
      else $error("restart did not reload watchdog and prescaler");
   AST_WD_TICK: assert property (slow_tick && !debug_mode_in && !wd_restart
      && wd_pre_q != `STT_WD_PRE_LAST |=> $stable(wd_cnt_q))
      else $error("watchdog moved between prescaled ticks");
   AST_WD_OVF: assert property (wd_ovf
      |=> stat_q[`STT_FLG_WDOG] && wd_cnt_q == $past(wdmr_q[15:0]))
      else $error("overflow did not flag and reload");
   AST_EXT_PULSE: assert property (wd_ovf && wdmr_q[`STT_BIT_EXTERNAL_PULSE_ENABLE]
      |=> !overflow_out_n_out)
      else $error("overflow pin not driven low");
   AST_EXT_QUIET: assert property (wd_ovf && !wdmr_q[`STT_BIT_EXTERNAL_PULSE_ENABLE] && ext_cnt_q == 4'h0
      |=> overflow_out_n_out)
      else $error("overflow pin pulsed while disabled");
   AST_SYS_RST: assert property (##1 system_reset_out
      == $past(wd_ovf && wdmr_q[`STT_BIT_OVERFLOW_RESET_ENABLE]))
      else $error("internal reset does not follow overflow and enable");
   AST_WDMR_KEEP: assert property (wdmr_wr && !wd_restart && !wd_tick
      |=> $stable(wd_cnt_q))
      else $error("watchdog mode write moved the counter");
   AST_DEBUG_HOLD: assert property (debug_mode_in && !wd_restart
      |=> $stable(wd_pre_q) && !$rose(system_reset_out))
      else $error("watchdog prescaler ran in debug");
   AST_RTC_INC: assert property (rt_evt
      |=> rtc_q == $past(rtc_inc) && stat_q[`STT_FLG_RINC])
      else $error("real-time increment not counted or flagged");
   AST_RTC_WRAP: assert property (rt_evt && rtc_q == 20'hfffff |=> rtc_q == 20'h00000)
      else $error("real-time counter did not wrap");
   AST_RTMR_WR: assert property (rtmr_wr
      |=> rtc_q == 20'h00000 && rt_pre_q == $past(apb_in.pwdata[15:0]))
      else $error("real-time mode write did not restart");
   AST_ALARM: assert property (rt_evt && rtc_inc == alrm_q |=> stat_q[`STT_FLG_ALRM])
      else $error("alarm match not flagged");
   AST_SR_CLEAR: assert property (stat_rd && stat_set == 4'h0 |=> stat_q == 4'h0)
      else $error("status read did not clear flags");
   AST_SR_STICKY: assert property (!stat_rd && stat_q[`STT_FLG_PER]
      |=> stat_q[`STT_FLG_PER])
      else $error("periodic flag dropped without a read");
   AST_MASK_SET: assert property (ien_wr |=> (mask_q & $past(apb_in.pwdata[3:0]))
      == $past(apb_in.pwdata[3:0]))
      else $error("enable write did not set mask bits");
   AST_MASK_CLR: assert property (idis_wr |=> (mask_q & $past(apb_in.pwdata[3:0])) == 4'h0)
      else $error("disable write did not clear mask bits");
   AST_IRQ: assert property (|(stat_q & mask_q) |=> irq_out)
      else $error("masked flag did not raise interrupt");
   AST_IRQ_LOW: assert property (stat_q == 4'h0 |=> !irq_out)
      else $error("interrupt high with no flag set");

   COV_PER: cover property (per_evt ##1 stat_rd);
   COV_WD_OVF: cover property (wd_ovf && wdmr_q[`STT_BIT_EXTERNAL_PULSE_ENABLE]);
   COV_ALARM: cover property (alm_hit);
   COV_RESTART: cover property (wd_restart ##1 wd_tick);
endmodule : stt_top
`default_nettype wire

// ==== pkg/stt_cfg.svh ====
// offsets, field positions, reset values and counts of the system timer trio
// Function
// - periodic 16-bit down counter on slow ticks, zero sets periodic flag
// - periodic counter reloads from period value by itself after zero
// - any period register write reloads and restarts the periodic counter
// - period value zero gives 65536 slow ticks between zero events
// - watchdog 16-bit down counter ticks at slow clock divided by 128
// - control write with restart bit reloads watchdog and clears prescaler
// - watchdog overflow sets its flag, then reloads and restarts
// - overflow with external enable drives overflow pin low 8 slow cycles
// - overflow with reset enable raises the internal system reset
// - watchdog mode write only stores fields, counter keeps running
// - debug mode stops the watchdog prescaler, so no overflow occurs
// - watchdog value zero gives 65536 ticks of 128 slow cycles
// - 20-bit real-time up counter fed by divider resetting to 0x8000
// - real-time counter wraps to zero after 1048576 increments
// - real-time counter compared with alarm, equality sets alarm flag
// - alarm resets to zero, matching only after a full wrap
// - each real-time increment sets the increment flag
// - real-time mode write reloads divider and clears the counter
// - four status flags stay set until a status read clears them
// - enable sets mask bits, disable clears them, mask reads back
// - divide value zero gives 65536 slow cycles per increment
`ifndef STT_CFG_SVH
`define STT_CFG_SVH
`define STT_OFS_CTRL 8'h00
`define STT_OFS_PIMR 8'h04
`define STT_OFS_WDMR 8'h08
`define STT_OFS_RTMR 8'h0c
`define STT_OFS_STAT 8'h10
`define STT_OFS_IEN 8'h14
`define STT_OFS_IDIS 8'h18
`define STT_OFS_IMSK 8'h1c
`define STT_OFS_ALRM 8'h20
`define STT_OFS_CURR 8'h24
`define STT_BIT_RESTART 0
`define STT_BIT_OVERFLOW_RESET_ENABLE 16
`define STT_BIT_EXTERNAL_PULSE_ENABLE 17
`define STT_FLG_PER 0
`define STT_FLG_WDOG 1
`define STT_FLG_RINC 2
`define STT_FLG_ALRM 3
`define STT_RST_PIMR 16'h0000
`define STT_RST_WDMR 18'h20000
`define STT_RST_RTMR 16'h8000
`define STT_RST_ALRM 20'h00000
`define STT_WD_PRE_LAST 7'h7f
`define STT_EXT_PULSE 4'h8
`endif

// ==== pkg/stt_pkg.sv ====
// types of the system timer trio
package stt_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } stt_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } stt_apb_rsp_t;
   typedef struct packed {
      logic evt;
      logic [15:0] nxt;
   } stt_dn_t;
endpackage : stt_pkg

// ==== tb/stt_tb.sv ====
// self-checking bench for the system timer trio over apb
`timescale 1ns/10ps
`default_nettype none
`include "stt_cfg.svh"
module testbench;
   logic clk_sys_in;
   logic rst_n_in;
   logic slow_q;
   logic debug_q;
   logic clk_en;
   stt_pkg::stt_apb_req_t req;
   stt_pkg::stt_apb_rsp_t rsp;
   logic irq;
   logic ovf_n;
   logic sys_rst;
   logic last_err;
   int fails;
   int n_checks;
   int n_rst = 0;
   logic [7:0] ofs [7];
   logic [31:0] rv [7];

   stt_top dut (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en),
      .slow_clock_in(slow_q),
      .debug_mode_in(debug_q),
      .apb_in(req),
      .apb_out(rsp),
      .irq_out(irq),
      .overflow_out_n_out(ovf_n),
      .system_reset_out(sys_rst)
   );

   always #5 clk_sys_in = ~clk_sys_in;

   // reset is a one-clock pulse, so it is counted rather than sampled
   always @(posedge clk_sys_in)
      if (sys_rst === 1'b1)
         n_rst <= n_rst + 1;

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= a;
      req.pwdata <= wd;
      @(posedge clk_sys_in);
      req.penable <= 1'b1;
      do
      begin
         @(posedge clk_sys_in);
         n++;
      end
      while (rsp.pready !== 1'b1 && n < 20);
      rd = rsp.prdata;
      last_err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (n >= 20)
         fails++;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, a, d, x);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      apb(1'b0, a, 32'h0, x);
      chk(x, e);
   endtask : rd

   // one slow tick is ten master cycles, so every rising edge is seen
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge clk_sys_in);
         slow_q <= 1'b1;
         repeat (4) @(posedge clk_sys_in);
         slow_q <= 1'b0;
         repeat (5) @(posedge clk_sys_in);
      end
   endtask : ticks

   task automatic clks(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : clks

   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done

   initial
   begin
      repeat (60000) @(posedge clk_sys_in);
      fails++;
      print_verdict;
   end

   initial
   begin
      clk_sys_in = 1'b0;
      rst_n_in = 1'b0;
      slow_q = 1'b0;
      debug_q = 1'b0;
      clk_en = 1'b1;
      req = '0;
      last_err = 1'b0;
      fails = 0;
      n_checks = 0;
      ofs = '{`STT_OFS_PIMR, `STT_OFS_WDMR, `STT_OFS_RTMR, `STT_OFS_STAT,
              `STT_OFS_IMSK, `STT_OFS_ALRM, `STT_OFS_CURR};
      rv = '{32'h0, 32'h20000, 32'h8000, 32'h0, 32'h0, 32'h0, 32'h0};
      repeat (2) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd(ofs[i], rv[i]);
      chk({31'h0, ovf_n}, 32'h1);
      done("reset");
      rd(8'h28, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      wr(8'h02, 32'h1);
      chk({31'h0, last_err}, 32'h1);
      wr(`STT_OFS_IMSK, 32'hf);
      rd(`STT_OFS_CTRL, 32'h0);
      wr(`STT_OFS_IEN, 32'hf);
      rd(`STT_OFS_IMSK, 32'hf);
      wr(`STT_OFS_IDIS, 32'h5);
      rd(`STT_OFS_IMSK, 32'ha);
      wr(`STT_OFS_IDIS, 32'hf);
      done("registers");
      wr(`STT_OFS_PIMR, 32'h3);
      rd(`STT_OFS_STAT, 32'h0);
      ticks(2);
      rd(`STT_OFS_STAT, 32'h0);
      ticks(1);
      chk({31'h0, irq}, 32'h0);
      wr(`STT_OFS_IEN, 32'h1);
      clks(3);
      chk({31'h0, irq}, 32'h1);
      rd(`STT_OFS_STAT, 32'h1);
      rd(`STT_OFS_STAT, 32'h0);
      clks(3);
      chk({31'h0, irq}, 32'h0);
      ticks(3);
      rd(`STT_OFS_STAT, 32'h1);
      ticks(2);
      wr(`STT_OFS_PIMR, 32'h3);
      ticks(2);
      rd(`STT_OFS_STAT, 32'h0);
      ticks(1);
      rd(`STT_OFS_STAT, 32'h1);
      // enable low must freeze the slow edge detector and every counter
      clk_en <= 1'b0;
      ticks(3);
      clk_en <= 1'b1;
      rd(`STT_OFS_STAT, 32'h0);
      ticks(3);
      rd(`STT_OFS_STAT, 32'h1);
      wr(`STT_OFS_PIMR, 32'h0);
      wr(`STT_OFS_IDIS, 32'h1);
      done("periodic");
      wr(`STT_OFS_RTMR, 32'h2);
      wr(`STT_OFS_ALRM, 32'h3);
      rd(`STT_OFS_ALRM, 32'h3);
      rd(`STT_OFS_STAT, 32'h0);
      ticks(4);
      rd(`STT_OFS_CURR, 32'h2);
      rd(`STT_OFS_CURR, 32'h2);
      rd(`STT_OFS_STAT, 32'h4);
      ticks(2);
      rd(`STT_OFS_CURR, 32'h3);
      rd(`STT_OFS_STAT, 32'hc);
      wr(`STT_OFS_RTMR, 32'h2);
      rd(`STT_OFS_CURR, 32'h0);
      wr(`STT_OFS_RTMR, 32'h0);
      rd(`STT_OFS_STAT, 32'h0);
      done("realtime");
      wr(`STT_OFS_WDMR, 32'h30001);
      wr(`STT_OFS_CTRL, 32'h1);
      ticks(127);
      rd(`STT_OFS_STAT, 32'h0);
      ticks(1);
      rd(`STT_OFS_STAT, 32'h2);
      chk(n_rst, 1);
      chk({31'h0, ovf_n}, 32'h0);
      ticks(7);
      chk({31'h0, ovf_n}, 32'h0);
      ticks(1);
      clks(2);
      chk({31'h0, ovf_n}, 32'h1);
      wr(`STT_OFS_CTRL, 32'h1);
      ticks(100);
      wr(`STT_OFS_CTRL, 32'h1);
      ticks(127);
      rd(`STT_OFS_STAT, 32'h0);
      ticks(1);
      rd(`STT_OFS_STAT, 32'h2);
      chk(n_rst, 2);
      ticks(100);
      wr(`STT_OFS_CTRL, 32'h0);
      wr(`STT_OFS_WDMR, 32'h1);
      ticks(27);
      rd(`STT_OFS_STAT, 32'h0);
      ticks(1);
      rd(`STT_OFS_STAT, 32'h2);
      chk(n_rst, 2);
      chk({31'h0, ovf_n}, 32'h1);
      debug_q <= 1'b1;
      ticks(200);
      rd(`STT_OFS_STAT, 32'h0);
      debug_q <= 1'b0;
      done("watchdog");
      print_verdict;
   end
endmodule : testbench
`default_nettype wire
